// [testbench/fwp_checker_properties.sv]
/*
 * Assertion checker for the flash write-protect sequencer, bound to its top.
 * Assumes cs_n_i stays high through reset and op times are shortened.
 */
module fwp_checker #(
	parameter longint unsigned CHIP_ERASE_CYCLES = 64'd100
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic write_protect_n_i,
	input wire logic four_line_command_mode_i,
	input wire logic [1:0] four_line_dummy_sel_i,
	input wire logic [11:0] rd_addr_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [15:0] status_o,
	input wire fwp_pkg::fwp_dummy_t dummy_o,
	input wire logic deep_power_down_o,
	input wire logic suspended_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Busy run length; loose, as the suspend latency adds to it
	logic [31:0] busy_cnt_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) busy_cnt_q <= '0;
		else if (status_o[0]) busy_cnt_q <= busy_cnt_q + 32'h1;
		else busy_cnt_q <= '0;
	end
	sequence s_idle3;
		(!status_o[0])[*3];
	endsequence
	a_dummy_single: assert property (!four_line_command_mode_i |=> dummy_o.fast == 4'h8
		&& dummy_o.dual_io == 4'h4 && dummy_o.quad_io == 4'h6 && dummy_o.dual_out == 4'h8 && dummy_o.quad_out == 4'h8)
		else $error("single-line dummy counts wrong");
	a_dummy_four: assert property (four_line_command_mode_i |=>
		dummy_o.fast == 4'h4 + {1'b0, $past(four_line_dummy_sel_i), 1'b0}
		&& dummy_o.quad_io == dummy_o.fast && dummy_o.burst == dummy_o.fast)
		else $error("four-line dummy counts wrong");
	a_busy_bound: assert property (busy_cnt_q <= CHIP_ERASE_CYCLES + 64'd3100)
		else $error("busy held too long");
	a_susp_idle: assert property (suspended_o && $past(suspended_o) |-> !status_o[0])
		else $error("busy while suspended");
	a_wel_drop: assert property ($fell(status_o[0]) |=> !status_o[1] || suspended_o)
		else $error("write latch kept after operation");
	a_dpd_frozen: assert property (deep_power_down_o && $past(deep_power_down_o) |-> $stable(status_o))
		else $error("status changed in power-down");
	a_wp_freeze: assert property ((!write_protect_n_i)[*7] |-> $stable(status_o[8:2]))
		else $error("protect bits changed with pin low");
	a_array_hold: assert property (s_idle3 ##0 $stable(rd_addr_i) |=> $stable(rd_data_o))
		else $error("array changed with no operation");
	a_reset_state: assert property ($fell(rst_i) |-> status_o == 16'h0000 && rd_data_o == 8'hFF
		&& !suspended_o && !deep_power_down_o)
		else $error("state after reset wrong");
endmodule // fwp_checker

bind fwp_flash_write_protect_timing fwp_checker #(.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)) CHK (
	.clk_i(clk_i), .rst_i(rst_i), .write_protect_n_i(write_protect_n_i),
	.four_line_command_mode_i(four_line_command_mode_i), .four_line_dummy_sel_i(four_line_dummy_sel_i),
	.rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .status_o(status_o), .dummy_o(dummy_o),
	.deep_power_down_o(deep_power_down_o), .suspended_o(suspended_o)
);

// [testbench/fwp_spi_host.sv]
/*
 * SPI host model: mode 0 frames on a 15 ns link clock, MSB first.
 * Assumes its tasks are called one at a time by the bench.
 */
module fwp_spi_host (
	// Link
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Select high from power-up; clock still outside frames
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Sends v[n-1:0]; released data line flips so no stale bit looks valid
	task automatic xfer(input logic [39:0] v, input int n);
		#3.1 cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			mosi_o = v[i];
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		#7.5 cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#120;
	endtask
	// Long hold-off after resume so the operation advances
	task automatic resume();
		xfer(40'h7A, 8);
		#100us;
	endtask
endmodule // fwp_spi_host

// [testbench/tb_flash_write_protect_timing.sv]
/*
 * Self-checking bench for the flash write-protect sequencer: frames via the host
 * model, level inputs at the falling edge. Assumes shortened operation times.
 */
module tb_flash_write_protect_timing;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int T_BYTE = 40;
	localparam int T_SECT = 50;
	localparam int T_BLK = 70;
	localparam int T_CHIP = 20000;
	localparam int T_SPRG = 30;
	localparam int T_SERS = 45;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk, cs_n, mosi;
	logic write_protect_n_i = 1'b1;
	logic mode_i = 1'b0;
	logic [1:0] sel_i = 2'h3;
	logic [11:0] rd_addr_i = 12'h010;
	logic [7:0] rd_data_o;
	logic [15:0] status_o;
	fwp_pkg::fwp_dummy_t dummy_o;
	logic dpd_o, susp_o;
	int failures = 0;
	int n_compared = 0;
	logic [7:0] opc [5] = '{8'h20, 8'hD8, 8'hC7, 8'h42, 8'h44};
	int lim [5] = '{T_SECT, T_BLK, T_CHIP, T_SPRG, T_SERS};
	always #5 clk_i = ~clk_i;
	fwp_spi_host HOST (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
	fwp_flash_write_protect_timing #(
		.PAGE_PROG_CYCLES(64'd60), .BYTE_PROG_CYCLES(T_BYTE), .SECTOR_ERASE_CYCLES(T_SECT),
		.BLOCK_ERASE_CYCLES(T_BLK), .CHIP_ERASE_CYCLES(T_CHIP), .SEC_PROG_CYCLES(T_SPRG), .SEC_ERASE_CYCLES(T_SERS)
	) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
		.write_protect_n_i(write_protect_n_i), .four_line_command_mode_i(mode_i), .four_line_dummy_sel_i(sel_i),
		.rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .status_o(status_o), .dummy_o(dummy_o),
		.deep_power_down_o(dpd_o), .suspended_o(susp_o)
	);
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for the busy bit to reach lvl
	task automatic wait_busy(input string nm, input logic lvl, input int lim_c);
		int c;
		c = 0;
		while (status_o[0] !== lvl && c < lim_c) begin
			@(negedge clk_i);
			c++;
		end
		chk(nm, {15'h0, lvl}, {15'h0, status_o[0]});
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(negedge clk_i) rd_addr_i <= a;
		repeat (2) @(negedge clk_i);
		chk("array byte", {8'h0, exp}, {8'h0, rd_data_o});
	endtask
	// Latch set, then the top n bits of opcode, address, data
	task automatic op(input logic [7:0] o, input logic [23:0] a, input logic [7:0] d, input int n);
		HOST.xfer(40'h06, 8);
		HOST.xfer({o, a, d} >> (40 - n), n);
	endtask
	initial begin
		#1ms;
		failures++;
		end_sim();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i) rst_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		chk("reset status", 16'h0000, status_o);
		rd(12'h010, 8'hFF);
		rd(12'hFFF, 8'hFF);
		chk("single dummies", 16'h8468, dummy_o[23:8]);
		chk("quad out dummies", 16'h0008, {12'h0, dummy_o.quad_out});
		for (int s = 0; s < 4; s++) begin
			@(negedge clk_i);
			mode_i <= 1'b1;
			sel_i <= 2'(s);
			repeat (2) @(negedge clk_i);
			chk("four-line dummies", {4'h0, {3{4'(4 + 2 * s)}}}, {4'h0, dummy_o.fast, dummy_o.quad_io, dummy_o.burst});
		end
		@(negedge clk_i) mode_i <= 1'b0;
		HOST.xfer({8'h02, 24'h000010, 8'h5A}, 40);
		chk("unlatched program", 16'h0000, status_o);
		rd(12'h010, 8'hFF);
		op(8'h02, 24'h000010, 8'h5A, 39);
		chk("short frame", 16'h0002, status_o);
		rd(12'h010, 8'hFF);
		HOST.xfer({8'h02, 24'h000010, 8'h5A}, 40);
		chk("program busy", 16'h0001, status_o);
		wait_busy("program end", 1'b0, T_BYTE);
		chk("after program", 16'h0000, status_o);
		rd(12'h010, 8'h5A);
		for (int k = 0; k < 5; k++) begin
			op(8'h02, 24'h000020, 8'h00, 40);
			wait_busy("program end", 1'b0, T_BYTE);
			op(opc[k], 24'h000020, 8'h00, (k == 2) ? 8 : 32);
			chk("op busy", 16'h0001, status_o);
			wait_busy("op end", 1'b0, lim[k]);
			chk("op latch", 16'h0000, status_o);
			rd(12'h020, (k < 3) ? 8'hFF : 8'h00);
		end
		op(8'hC7, 24'h0, 8'h0, 8);
		HOST.xfer(40'h75, 8);
		chk("suspend pending", 16'h0001, status_o);
		wait_busy("suspend latency", 1'b0, 3000);
		chk("suspended", 16'h0001, {15'h0, susp_o});
		HOST.resume();
		chk("resumed", 16'h0000, {15'h0, susp_o});
		chk("resume busy", 16'h0001, {15'h0, status_o[0]});
		wait_busy("erase end", 1'b0, T_CHIP);
		op(8'h01, 24'h240000, 8'h00, 16);
		wait_busy("status write", 1'b0, 100);
		chk("protect bits", 16'h0009, {11'h0, status_o[6:2]});
		op(8'h02, 24'h000030, 8'h00, 40);
		chk("protected program", 16'h0000, {15'h0, status_o[0]});
		rd(12'h030, 8'hFF);
		@(negedge clk_i) write_protect_n_i <= 1'b0;
		op(8'h01, 24'h000000, 8'h00, 16);
		wait_busy("locked write", 1'b0, 100);
		chk("locked bits", 16'h0009, {11'h0, status_o[6:2]});
		@(negedge clk_i) write_protect_n_i <= 1'b1;
		op(8'h01, 24'h000000, 8'h00, 16);
		wait_busy("unlocked write", 1'b0, 100);
		chk("cleared bits", 16'h0000, {11'h0, status_o[6:2]});
		HOST.xfer(40'hB9, 8);
		chk("power down", 16'h0001, {15'h0, dpd_o});
		HOST.xfer(40'h06, 8);
		chk("latch in power down", 16'h0000, {15'h0, status_o[1]});
		HOST.xfer(40'hAB, 8);
		chk("released", 16'h0000, {15'h0, dpd_o});
		end_sim();
	end
endmodule // tb_flash_write_protect_timing

// [verilog/fwp_flash_write_protect_timing.sv]
/*
 * Write-side control of a serial NOR flash: command framing on the SPI clock,
 * write latch, block protection, write-protect pin, deep power-down, program/erase
 * timing and suspend, and dummy clock selection for the read commands.
 * Assumes the host drives sclk_i and cs_n_i, keeps supply_to_select_delay after power-up, and waits
 * the resume-to-suspend times itself. The array is a small byte model.
 */

module fwp_flash_write_protect_timing #(
	parameter int unsigned MEM_BYTES = 4096,
	parameter longint unsigned PAGE_PROG_CYCLES = fwp_pkg::PAGE_PROG_CYC,
	parameter longint unsigned BYTE_PROG_CYCLES = fwp_pkg::BYTE_PROG_CYC,
	parameter longint unsigned SECTOR_ERASE_CYCLES = fwp_pkg::SECTOR_ERASE_CYC,
	parameter longint unsigned BLOCK_ERASE_CYCLES = fwp_pkg::BLOCK_ERASE_CYC,
	parameter longint unsigned CHIP_ERASE_CYCLES = fwp_pkg::CHIP_ERASE_CYC,
	parameter longint unsigned SEC_PROG_CYCLES = fwp_pkg::SEC_PROG_CYC,
	parameter longint unsigned SEC_ERASE_CYCLES = fwp_pkg::SEC_ERASE_CYC
) (
	// System
	input wire logic clk_i,
	input wire logic rst_i,
	// SPI link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic write_protect_n_i,
	// Configuration
	input wire logic four_line_command_mode_i,
	input wire logic [1:0] four_line_dummy_sel_i,
	// Array read port
	input wire logic [11:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// Status
	output logic [15:0] status_o,
	output fwp_pkg::fwp_dummy_t dummy_o,
	output logic deep_power_down_o,
	output logic suspended_o
);

	// Link domain: shift register and bit counter, reset by the frame itself
	logic [7:0] sh_q;
	logic [5:0] bytes_q;
	logic [2:0] bit_q;
	logic [7:0] op_q;
	logic [23:0] addr_q;
	logic [7:0] data_q;
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_q <= 3'h0;
			bytes_q <= 6'h00;
			sh_q <= 8'h00;
		end else begin
			sh_q <= {sh_q[6:0], mosi_i};
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				if (bytes_q != 6'h3F)
					bytes_q <= bytes_q + 6'h01;
			end
		end
	end

	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			data_q <= 8'h00;
		end else if (!cs_n_i && bit_q == 3'h7) begin
			unique case (bytes_q)
				6'h00: op_q <= {sh_q[6:0], mosi_i};
				6'h01: addr_q[23:16] <= {sh_q[6:0], mosi_i};
				6'h02: addr_q[15:8] <= {sh_q[6:0], mosi_i};
				6'h03: addr_q[7:0] <= {sh_q[6:0], mosi_i};
				6'h04: data_q <= {sh_q[6:0], mosi_i};
				default: ;
			endcase
		end
	end

	// Frame end: counts held stable while select is high, then a toggle to the core
	logic frame_tgl_q;
	logic [5:0] frame_bytes_q;
	logic frame_whole_q;
	always_ff @(posedge cs_n_i or posedge rst_i) begin
		if (rst_i) begin
			frame_tgl_q <= 1'b0;
			frame_bytes_q <= 6'h00;
			frame_whole_q <= 1'b0;
		end else begin
			frame_tgl_q <= ~frame_tgl_q;
			frame_bytes_q <= bytes_q;
			frame_whole_q <= (bit_q == 3'h0) && (bytes_q != 6'h00);
		end
	end

	// Core domain: three-stage sync of toggle and pin, agreement of last two
	logic [2:0] tgl_sync_q;
	logic [2:0] wp_sync_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tgl_sync_q <= 3'h0;
			wp_sync_q <= 3'h7;
		end else begin
			tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_q};
			wp_sync_q <= {wp_sync_q[1:0], write_protect_n_i};
		end
	end

	logic tgl_seen_q;
	logic wp_n_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tgl_seen_q <= 1'b0;
			wp_n_q <= 1'b1;
		end else begin
			if (tgl_sync_q[1] == tgl_sync_q[2])
				tgl_seen_q <= tgl_sync_q[2];
			if (wp_sync_q[1] == wp_sync_q[2])
				wp_n_q <= wp_sync_q[2];
		end
	end

	logic cmd_stb;
	assign cmd_stb = (tgl_sync_q[1] == tgl_sync_q[2]) && (tgl_sync_q[2] != tgl_seen_q);

	// Frame data is stable for as long as select stays high after the toggle
	fwp_pkg::fwp_cmd_t cmd;
	assign cmd = '{opcode: op_q, addr: addr_q, data: data_q, nbytes: frame_bytes_q, whole: frame_whole_q};

	// Status and mode state
	logic wel_q;
	logic [4:0] bp_q;
	logic [1:0] lock_q;
	logic dpd_q;
	fwp_pkg::fwp_state_t state_q;
	fwp_pkg::fwp_state_t resume_state_q;
	logic [31:0] timer_q;
	logic [11:0] op_addr_q;
	logic [1:0] op_kind_q;
	logic [7:0] op_data_q;

	// Protected range from the block protect bits, in 4 KB sector units
	logic [7:0] prot_lo;
	logic [7:0] prot_hi;
	logic prot_none;
	always_comb begin
		logic [7:0] span;
		span = 8'h00;
		prot_none = 1'b0;
		prot_lo = 8'h00;
		prot_hi = 8'hFF;
		if (bp_q[2:0] == 3'h0) begin
			prot_none = 1'b1;
		end else if (bp_q[2:1] == 2'h3 || (!bp_q[4] && bp_q[2:0] == 3'h5)) begin
			prot_lo = 8'h00;
			prot_hi = 8'hFF;
		end else begin
			if (bp_q[4])
				span = bp_q[2] ? 8'h08 : (8'h01 << (bp_q[1:0] - 2'h1));
			else
				span = 8'h10 << (bp_q[2] ? 3'h3 : 3'(bp_q[1:0] - 2'h1));
			if (bp_q[3]) begin
				prot_lo = 8'h00;
				prot_hi = span - 8'h01;
			end else begin
				prot_lo = 8'(9'h100 - {1'b0, span});
				prot_hi = 8'hFF;
			end
		end
	end

	// Target range of a command in sectors, checked against protection
	logic [7:0] tgt_lo;
	logic [7:0] tgt_hi;
	logic hits_prot;
	always_comb begin
		tgt_lo = cmd.addr[19:12];
		tgt_hi = cmd.addr[19:12];
		if (cmd.opcode == fwp_pkg::OP_BLOCK64_ERASE) begin
			tgt_lo = {cmd.addr[19:16], 4'h0};
			tgt_hi = {cmd.addr[19:16], 4'hF};
		end else if (cmd.opcode == fwp_pkg::OP_CHIP_ERASE) begin
			tgt_lo = 8'h00;
			tgt_hi = 8'hFF;
		end
		hits_prot = !prot_none && (tgt_lo <= prot_hi) && (tgt_hi >= prot_lo);
	end

	logic is_write_cmd;
	assign is_write_cmd = (cmd.opcode == fwp_pkg::OP_PAGE_PROGRAM) || (cmd.opcode == fwp_pkg::OP_SECTOR_ERASE)
		|| (cmd.opcode == fwp_pkg::OP_BLOCK64_ERASE) || (cmd.opcode == fwp_pkg::OP_CHIP_ERASE)
		|| (cmd.opcode == fwp_pkg::OP_SEC_REG_PROGRAM) || (cmd.opcode == fwp_pkg::OP_SEC_REG_ERASE);
	logic accept;
	assign accept = cmd_stb && cmd.whole && !dpd_q;
	logic idle;
	assign idle = (state_q == fwp_pkg::FWP_IDLE);
	logic start_op;
	assign start_op = accept && idle && wel_q && is_write_cmd && !hits_prot;

	// Write latch, protection bits and deep power-down
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wel_q <= 1'b0;
			bp_q <= 5'h00;
			lock_q <= 2'h0;
			dpd_q <= 1'b0;
		end else begin
			if (cmd_stb && dpd_q && cmd.whole && cmd.opcode == fwp_pkg::OP_RELEASE_DPD)
				dpd_q <= 1'b0;
			if (accept && idle) begin
				unique case (cmd.opcode)
					fwp_pkg::OP_SET_WRITE_LATCH: wel_q <= 1'b1;
					fwp_pkg::OP_CLR_WRITE_LATCH: wel_q <= 1'b0;
					fwp_pkg::OP_DEEP_POWER_DOWN: dpd_q <= 1'b1;
					fwp_pkg::OP_WRITE_STATUS: begin
						if (wel_q) begin
							wel_q <= 1'b0;
							if (wp_n_q) begin
								bp_q <= cmd.addr[22:18];
								lock_q <= {1'b0, cmd.addr[23]};
							end
						end
					end
					default: begin
						if (start_op)
							wel_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Operation length by command
	function automatic logic [31:0] op_cycles(input logic [7:0] opc, input logic [5:0] nb);
		unique case (opc)
			fwp_pkg::OP_PAGE_PROGRAM: op_cycles = (nb <= 6'h05) ? 32'(BYTE_PROG_CYCLES) : 32'(PAGE_PROG_CYCLES);
			fwp_pkg::OP_SECTOR_ERASE: op_cycles = 32'(SECTOR_ERASE_CYCLES);
			fwp_pkg::OP_BLOCK64_ERASE: op_cycles = 32'(BLOCK_ERASE_CYCLES);
			fwp_pkg::OP_CHIP_ERASE: op_cycles = 32'(CHIP_ERASE_CYCLES);
			fwp_pkg::OP_SEC_REG_PROGRAM: op_cycles = 32'(SEC_PROG_CYCLES);
			default: op_cycles = 32'(SEC_ERASE_CYCLES);
		endcase
	endfunction

	// Operation sequencer; suspend freezes the remaining time
	logic [31:0] saved_q;
	logic op_done;
	assign op_done = (state_q == fwp_pkg::FWP_PROG || state_q == fwp_pkg::FWP_ERASE) && timer_q == 32'h0000_0001;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= fwp_pkg::FWP_IDLE;
			resume_state_q <= fwp_pkg::FWP_IDLE;
			timer_q <= 32'h0000_0000;
			saved_q <= 32'h0000_0000;
			op_addr_q <= 12'h000;
			op_kind_q <= 2'h0;
			op_data_q <= 8'h00;
		end else begin
			unique case (state_q)
				fwp_pkg::FWP_IDLE: begin
					if (start_op) begin
						timer_q <= op_cycles(cmd.opcode, cmd.nbytes);
						op_addr_q <= cmd.addr[11:0];
						op_data_q <= cmd.data;
						if (cmd.opcode == fwp_pkg::OP_PAGE_PROGRAM) begin
							state_q <= fwp_pkg::FWP_PROG;
							op_kind_q <= 2'h1;
						end else begin
							state_q <= fwp_pkg::FWP_ERASE;
							// Security register ops are timed only and leave the array alone
							op_kind_q <= (cmd.opcode == fwp_pkg::OP_CHIP_ERASE) ? 2'h3
								: (cmd.opcode == fwp_pkg::OP_SEC_REG_PROGRAM) ? 2'h0
								: (cmd.opcode == fwp_pkg::OP_SEC_REG_ERASE) ? 2'h0 : 2'h2;
						end
					end
				end
				fwp_pkg::FWP_PROG, fwp_pkg::FWP_ERASE: begin
					timer_q <= timer_q - 32'h0000_0001;
					if (op_done) begin
						state_q <= fwp_pkg::FWP_IDLE;
					end else if (cmd_stb && cmd.whole && cmd.opcode == fwp_pkg::OP_SUSPEND) begin
						resume_state_q <= state_q;
						saved_q <= timer_q;
						timer_q <= 32'(fwp_pkg::SUSPEND_CYC);
						state_q <= fwp_pkg::FWP_SUSP_WAIT;
					end
				end
				fwp_pkg::FWP_SUSP_WAIT: begin
					timer_q <= timer_q - 32'h0000_0001;
					if (timer_q == 32'h0000_0001)
						state_q <= fwp_pkg::FWP_SUSPENDED;
				end
				fwp_pkg::FWP_SUSPENDED: begin
					// Resume spacing before the next suspend is the host's duty
					if (cmd_stb && cmd.whole && cmd.opcode == fwp_pkg::OP_RESUME) begin
						timer_q <= saved_q;
						state_q <= resume_state_q;
					end
				end
				default: state_q <= fwp_pkg::FWP_IDLE;
			endcase
		end
	end

	// Small array model; the write lands at completion only
	logic [7:0] mem_q [MEM_BYTES];
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < MEM_BYTES; i++)
				mem_q[i] <= fwp_pkg::ERASED_BYTE;
		end else if (op_done) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				if (op_kind_q == 2'h3 || (op_kind_q == 2'h2 && i[11:0] == op_addr_q))
					mem_q[i] <= fwp_pkg::ERASED_BYTE;
				else if (op_kind_q == 2'h1 && i[11:0] == op_addr_q)
					mem_q[i] <= mem_q[i] & op_data_q;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			rd_data_o <= fwp_pkg::ERASED_BYTE;
		else
			rd_data_o <= mem_q[rd_addr_i];
	end

	// Dummy clocks per read command and mode
	logic [3:0] ql_dummy;
	assign ql_dummy = 4'h4 + {1'b0, four_line_dummy_sel_i, 1'b0};
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dummy_o <= '{fast: 4'h8, dual_io: 4'h4, quad_io: 4'h6, dual_out: 4'h8, quad_out: 4'h8, burst: 4'hA};
		end else if (four_line_command_mode_i) begin
			dummy_o <= '{fast: ql_dummy, dual_io: fwp_pkg::DUMMY_DUAL_IO_SINGLE, quad_io: ql_dummy,
				dual_out: fwp_pkg::DUMMY_FAST_SINGLE, quad_out: fwp_pkg::DUMMY_FAST_SINGLE, burst: ql_dummy};
		end else begin
			dummy_o <= '{fast: fwp_pkg::DUMMY_FAST_SINGLE, dual_io: fwp_pkg::DUMMY_DUAL_IO_SINGLE,
				quad_io: fwp_pkg::DUMMY_QUAD_IO_SINGLE, dual_out: fwp_pkg::DUMMY_FAST_SINGLE,
				quad_out: fwp_pkg::DUMMY_FAST_SINGLE, burst: fwp_pkg::DUMMY_FOUR_LINE_DEFAULT};
		end
	end

	// Status word
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= fwp_pkg::STATUS_RESET;
			deep_power_down_o <= 1'b0;
			suspended_o <= 1'b0;
		end else begin
			status_o <= fwp_pkg::STATUS_RESET;
			status_o[fwp_pkg::ST_BUSY] <= (state_q != fwp_pkg::FWP_IDLE) && (state_q != fwp_pkg::FWP_SUSPENDED);
			status_o[fwp_pkg::ST_WEL] <= wel_q;
			status_o[fwp_pkg::ST_BP_LO +: 5] <= bp_q;
			status_o[fwp_pkg::ST_LOCK0] <= lock_q[0];
			status_o[fwp_pkg::ST_LOCK1] <= lock_q[1];
			deep_power_down_o <= dpd_q;
			suspended_o <= (state_q == fwp_pkg::FWP_SUSPENDED);
		end
	end

endmodule // fwp_flash_write_protect_timing

// [verilog/fwp_pkg.sv]
/*
 * Package for the flash write-protect and timing sequencer: opcodes, dummy counts,
 * operation time limits, status bit positions and shared types.
 * Assumes a 100 MHz system clock and an SPI link clocked by the host.
 */
package fwp_pkg;

	localparam int unsigned CLK_MHZ = 100;

	// Opcodes
	localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] OP_SEC_REG_PROGRAM = 8'h42;
	localparam logic [7:0] OP_SEC_REG_ERASE = 8'h44;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_RELEASE_DPD = 8'hAB;
	localparam logic [7:0] OP_ENTER_FOUR_LINE = 8'h38;
	localparam logic [7:0] OP_EXIT_FOUR_LINE = 8'hFF;

	// Dummy clocks
	localparam logic [3:0] DUMMY_FAST_SINGLE = 4'h8;
	localparam logic [3:0] DUMMY_DUAL_IO_SINGLE = 4'h4;
	localparam logic [3:0] DUMMY_QUAD_IO_SINGLE = 4'h6;
	localparam logic [3:0] DUMMY_FOUR_LINE_DEFAULT = 4'hA;
	localparam logic [1:0] DUMMY_SEL_RESET = 2'h3;

	// Times, as printed
	localparam real T_SUSPEND_US = 30.0;
	localparam real T_PAGE_PROG_MS = 2.0;
	localparam real T_BYTE_PROG_US = 50.0;
	localparam real T_SECTOR_ERASE_MS = 450.0;
	localparam real T_BLOCK_ERASE_S = 1.2;
	localparam real T_CHIP_ERASE_S = 10.0;
	localparam real T_SEC_PROG_MS = 2.0;
	localparam real T_SEC_ERASE_MS = 240.0;

	// Longest times round down to whole cycles
	localparam int unsigned SUSPEND_CYC = int'($floor(T_SUSPEND_US * CLK_MHZ));
	localparam longint unsigned PAGE_PROG_CYC = longint'($floor(T_PAGE_PROG_MS * 1000.0 * CLK_MHZ));
	localparam longint unsigned BYTE_PROG_CYC = longint'($floor(T_BYTE_PROG_US * CLK_MHZ));
	localparam longint unsigned SECTOR_ERASE_CYC = longint'($floor(T_SECTOR_ERASE_MS * 1000.0 * CLK_MHZ));
	localparam longint unsigned BLOCK_ERASE_CYC = longint'($floor(T_BLOCK_ERASE_S * 1.0e6 * CLK_MHZ));
	localparam longint unsigned CHIP_ERASE_CYC = longint'($floor(T_CHIP_ERASE_S * 1.0e6 * CLK_MHZ));
	localparam longint unsigned SEC_PROG_CYC = longint'($floor(T_SEC_PROG_MS * 1000.0 * CLK_MHZ));
	localparam longint unsigned SEC_ERASE_CYC = longint'($floor(T_SEC_ERASE_MS * 1000.0 * CLK_MHZ));

	// Status bit positions
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_WEL = 1;
	localparam int unsigned ST_BP_LO = 2;
	localparam int unsigned ST_LOCK0 = 7;
	localparam int unsigned ST_LOCK1 = 8;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// Address and protection geometry
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned BLOCK64_SHIFT = 16;
	localparam int unsigned SECTOR_SHIFT = 12;

	typedef enum logic [2:0] {
		FWP_IDLE = 3'b000,
		FWP_PROG = 3'b001,
		FWP_ERASE = 3'b010,
		FWP_SUSP_WAIT = 3'b011,
		FWP_SUSPENDED = 3'b100
	} fwp_state_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] data;
		logic [5:0] nbytes;
		logic whole;
	} fwp_cmd_t;

	typedef struct packed {
		logic [3:0] fast;
		logic [3:0] dual_io;
		logic [3:0] quad_io;
		logic [3:0] dual_out;
		logic [3:0] quad_out;
		logic [3:0] burst;
	} fwp_dummy_t;

endpackage
